// ===== hdl/timer2_pin_sync.sv
// Purpose: Two-flop synchroniser with falling-edge pulse for one pin
// Assumes: Pin is asynchronous to core_clk_i
// Notes: Edge is judged only between second and third flop
`timescale 1ns/100ps
`default_nettype none
module timer2_pin_sync (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic pin_i,
	output logic level_o,
	output logic fall_o
);
	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
			prev_ff <= 1'b1;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign level_o = sync_ff;
	assign fall_o = prev_ff & ~sync_ff;
endmodule
`default_nettype wire

// ===== hdl/timer2_pkg.sv
// Purpose: Constants for the sixteen-bit reload/capture/clock-out timer
// Assumes: Registers reached over classic Wishbone, 8-bit data in low lane
// Notes: Register indices times four give the byte address
package timer2_pkg;
	localparam int ADR_W = 10;
	localparam logic [7:0] IDX_CONTROL = 8'hc8;
	localparam logic [7:0] IDX_MODE = 8'hc9;
	localparam logic [7:0] IDX_COUNT_LOW = 8'hca;
	localparam logic [7:0] IDX_COUNT_HIGH = 8'hcb;
	localparam logic [7:0] IDX_RELOAD_LOW = 8'hcc;
	localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcd;
	localparam logic [7:0] IDX_CONTROL_BIT = 8'hce;
	localparam int OVF_BIT = 7;
	localparam int EXT_BIT = 6;
	localparam int RX_BIT = 5;
	localparam int TX_BIT = 4;
	localparam int EXEN_BIT = 3;
	localparam int RUN_BIT = 2;
	localparam int SRC_BIT = 1;
	localparam int CAP_BIT = 0;
	localparam int UPDN_BIT = 0;
	localparam int CLKOUT_BIT = 1;
	localparam int BITWR_VAL_BIT = 3;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam int DIV_TIMER = 12;
	localparam int DIV_CLKOUT = 2;
endpackage

// ===== hdl/timer2_prescaler.sv
// Purpose: Oscillator dividers for the timer and clock-out rates
// Assumes: core_clk_i is the oscillator
// Notes: Ticks are one-cycle enables, never clocks
`timescale 1ns/100ps
`default_nettype none
module timer2_prescaler import timer2_pkg::*; #(
	parameter int TIMER_DIV = DIV_TIMER,
	parameter int CLKOUT_DIV = DIV_CLKOUT
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	timer2_tick_if.src tick
);
	logic [3:0] div_timer_ff;
	logic [3:0] div_clkout_ff;

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			div_timer_ff <= 4'h0;
		end else if (div_timer_ff == 4'(TIMER_DIV - 1)) begin
			div_timer_ff <= 4'h0;
		end else begin
			div_timer_ff <= div_timer_ff + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			div_clkout_ff <= 4'h0;
		end else if (div_clkout_ff == 4'(CLKOUT_DIV - 1)) begin
			div_clkout_ff <= 4'h0;
		end else begin
			div_clkout_ff <= div_clkout_ff + 4'h1;
		end
	end

	assign tick.div_timer_tick = (div_timer_ff == 4'(TIMER_DIV - 1));
	assign tick.div_clkout_tick = (div_clkout_ff == 4'(CLKOUT_DIV - 1));

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	chk_timer_tick_period: assert property (tick.div_timer_tick |-> ##12 tick.div_timer_tick)
		else $error("timer tick period wrong");
	chk_timer_tick_gap: assert property (tick.div_timer_tick |=> !tick.div_timer_tick [*8])
		else $error("timer tick too frequent");
	chk_clkout_tick_rate: assert property (tick.div_clkout_tick |=> !tick.div_clkout_tick ##1 tick.div_clkout_tick)
		else $error("clock-out tick period wrong");
endmodule
`default_nettype wire

// ===== hdl/timer2_reload_capture_clockout.sv
// Purpose: Sixteen-bit timer/counter with reload, capture, up/down and clock-out
// Assumes: Classic Wishbone slave, one oscillator clock, synchronous reset
// Notes: Every access acks on the second edge; writes land on the ack edge
`timescale 1ns/100ps
`default_nettype none

module timer2_reload_capture_clockout import timer2_pkg::*; (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic count_clock_pin_i,
	output logic count_clock_pin_o,
	output logic count_clock_pin_oe_n_o,
	input wire logic direction_trigger_pin_i,
	input wire logic timer1_overflow_i,
	output logic rx_baud_clock_o,
	output logic tx_baud_clock_o,
	output logic timer_irq_req_o
);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic reg_hit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
		return adr[ADR_W-1:2] == idx;
	endfunction

	logic [7:0] control_ff;
	logic [1:0] mode_ff;
	logic [7:0] count_low_ff;
	logic [7:0] count_high_ff;
	logic [7:0] reload_low_ff;
	logic [7:0] reload_high_ff;
	logic clkout_ff;
	logic rx_baud_ff;
	logic tx_baud_ff;
	logic ack_ff;
	logic [31:0] rdata_ff;
	logic pin_level;
	logic pin_fall;
	logic dir_level;
	logic dir_fall;
	logic [15:0] count;
	logic [15:0] reload;
	logic wr_go;
	logic wr_control;
	logic wr_bit;
	logic baud_mode;
	logic clock_out;
	logic tick_sel;
	logic advance;
	logic updn_mode;
	logic count_down;
	logic up_wrap;
	logic dn_wrap;
	logic wrap;
	logic ext_evt;
	logic capture;
	logic ext_reload;
	logic ovf_set;
	logic ext_set;
	logic ext_toggle;
	logic reload_on_wrap;
	logic [7:0] sw_control;
	logic [7:0] nxt_control;
	logic [15:0] nxt_count;
	logic [7:0] rd_mux;

	timer2_tick_if ticks ();

	timer2_prescaler u_prescaler (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.tick(ticks.src)
	);

	timer2_pin_sync u_count_pin_sync (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.pin_i(count_clock_pin_i),
		.level_o(pin_level),
		.fall_o(pin_fall)
	);

	timer2_pin_sync u_dir_pin_sync (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.pin_i(direction_trigger_pin_i),
		.level_o(dir_level),
		.fall_o(dir_fall)
	);

	////////////////////////////////////////////////////////////////////////////
	// Timer datapath decode
	always_comb begin
		count = {count_high_ff, count_low_ff};
		reload = {reload_high_ff, reload_low_ff};
		wr_go = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0];
		wr_control = wr_go & reg_hit(wb_adr_i, IDX_CONTROL);
		wr_bit = wr_go & reg_hit(wb_adr_i, IDX_CONTROL_BIT);
		baud_mode = control_ff[RX_BIT] | control_ff[TX_BIT];
		clock_out = mode_ff[CLKOUT_BIT];
		// Clock-out must run from the internal rate; source bit is software's job
		if (control_ff[SRC_BIT]) begin
			tick_sel = pin_fall;
		end else if (clock_out) begin
			tick_sel = ticks.div_clkout_tick;
		end else begin
			tick_sel = ticks.div_timer_tick;
		end
		advance = control_ff[RUN_BIT] & tick_sel;
		updn_mode = mode_ff[UPDN_BIT] & ~baud_mode & ~control_ff[CAP_BIT];
		count_down = updn_mode & ~dir_level;
		up_wrap = advance & ~count_down & (count == COUNT_MAX);
		dn_wrap = advance & count_down & (count == reload);
		wrap = up_wrap | dn_wrap;
		ext_evt = dir_fall & control_ff[EXEN_BIT] & ~baud_mode;
		capture = ext_evt & control_ff[CAP_BIT];
		ext_reload = ext_evt & ~control_ff[CAP_BIT] & ~updn_mode;
		ovf_set = wrap & ~baud_mode & ~clock_out;
		ext_set = capture | ext_reload;
		ext_toggle = wrap & updn_mode;
		// Capture mode keeps its captured value, so an overflow rolls over to zero unless serial clock or clock-out mode is on
		reload_on_wrap = ~control_ff[CAP_BIT] | baud_mode | clock_out;
	end

	////////////////////////////////////////////////////////////////////////////
	// Next count: wrap, trigger reload, then a step
	always_comb begin
		nxt_count = count;
		if ((up_wrap && reload_on_wrap) || ext_reload) begin
			nxt_count = reload;
		end else if (dn_wrap) begin
			nxt_count = COUNT_MAX;
		end else if (advance && count_down) begin
			nxt_count = count - 16'h0001;
		end else if (advance) begin
			nxt_count[7:0] = count_low_ff + 8'h01;
			nxt_count[15:8] = count_high_ff + {7'h00, &count_low_ff};
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			count_low_ff <= 8'h00;
			count_high_ff <= 8'h00;
		end else begin
			// Software write wins over a step in the same cycle
			count_low_ff <= (wr_go && reg_hit(wb_adr_i, IDX_COUNT_LOW)) ?
				wb_dat_i[7:0] : nxt_count[7:0];
			count_high_ff <= (wr_go && reg_hit(wb_adr_i, IDX_COUNT_HIGH)) ?
				wb_dat_i[7:0] : nxt_count[15:8];
		end
	end

	// Capture wins over a software write so a trigger event is never lost
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			reload_low_ff <= 8'h00;
			reload_high_ff <= 8'h00;
		end else if (capture) begin
			reload_low_ff <= count_low_ff;
			reload_high_ff <= count_high_ff;
		end else begin
			if (wr_go && reg_hit(wb_adr_i, IDX_RELOAD_LOW)) begin
				reload_low_ff <= wb_dat_i[7:0];
			end
			if (wr_go && reg_hit(wb_adr_i, IDX_RELOAD_HIGH)) begin
				reload_high_ff <= wb_dat_i[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register with single-bit write port; hardware sets win over clears
	always_comb begin
		sw_control = control_ff;
		if (wr_control) begin
			sw_control = wb_dat_i[7:0];
		end else if (wr_bit) begin
			sw_control[wb_dat_i[2:0]] = wb_dat_i[BITWR_VAL_BIT];
		end
		nxt_control = sw_control;
		nxt_control[OVF_BIT] = sw_control[OVF_BIT] | ovf_set;
		if (updn_mode) begin
			nxt_control[EXT_BIT] = sw_control[EXT_BIT] ^ ext_toggle;
		end else begin
			nxt_control[EXT_BIT] = sw_control[EXT_BIT] | ext_set;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			control_ff <= CONTROL_RESET;
		end else begin
			control_ff <= nxt_control;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			mode_ff <= MODE_RESET;
		end else if (wr_go && reg_hit(wb_adr_i, IDX_MODE)) begin
			mode_ff <= wb_dat_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Clock-out pin and serial clock routing
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			clkout_ff <= 1'b0;
		end else if (!clock_out) begin
			clkout_ff <= 1'b0;
		end else if (wrap) begin
			clkout_ff <= ~clkout_ff;
		end
	end

	// Overflow pulses replace timer 1 overflows; RX_BIT and TX_BIT each select one clock on its own
	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rx_baud_ff <= 1'b0;
			tx_baud_ff <= 1'b0;
		end else begin
			rx_baud_ff <= control_ff[RX_BIT] ? wrap : timer1_overflow_i;
			tx_baud_ff <= control_ff[TX_BIT] ? wrap : timer1_overflow_i;
		end
	end

	assign count_clock_pin_o = clkout_ff;
	assign count_clock_pin_oe_n_o = ~clock_out;
	assign rx_baud_clock_o = rx_baud_ff;
	assign tx_baud_clock_o = tx_baud_ff;
	// External flag requests only outside up/down mode
	assign timer_irq_req_o = control_ff[OVF_BIT] | (control_ff[EXT_BIT] & ~updn_mode);

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack on second edge, unmapped reads zero
	always_comb begin
		rd_mux = 8'h00;
		if (reg_hit(wb_adr_i, IDX_CONTROL)) begin
			rd_mux = control_ff;
		end else if (reg_hit(wb_adr_i, IDX_MODE)) begin
			rd_mux = {6'h00, mode_ff};
		end else if (reg_hit(wb_adr_i, IDX_COUNT_LOW)) begin
			rd_mux = count_low_ff;
		end else if (reg_hit(wb_adr_i, IDX_COUNT_HIGH)) begin
			rd_mux = count_high_ff;
		end else if (reg_hit(wb_adr_i, IDX_RELOAD_LOW)) begin
			rd_mux = reload_low_ff;
		end else if (reg_hit(wb_adr_i, IDX_RELOAD_HIGH)) begin
			rd_mux = reload_high_ff;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!resetn_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack_ff) begin
			rdata_ff <= {24'h00_0000, rd_mux};
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);

	// Register bus checks
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	// Timer checks
	chk_run_hold: assert property (!control_ff[RUN_BIT] && !ext_reload && !wr_go |=> $stable(count))
		else $error("count moved while stopped");
	chk_up_wrap_reload: assert property (up_wrap && reload_on_wrap && !wr_go |=> count == $past(reload))
		else $error("overflow did not load reload value");
	chk_wrap_to_zero: assert property (up_wrap && !reload_on_wrap && !wr_go |=> count == 16'h0000)
		else $error("capture mode overflow did not roll over");
	chk_count_step: assert property (advance && !count_down && !wrap && !ext_reload && !wr_go |=> count == $past(count) + 16'h0001)
		else $error("count did not step by one");
	chk_trigger_reload: assert property (ext_reload && !wr_go |=> count == $past(reload))
		else $error("trigger edge did not reload count");
	chk_ext_trigger_flag: assert property (ext_set |=> control_ff[EXT_BIT])
		else $error("external flag not set by trigger");
	chk_down_wrap_max: assert property (dn_wrap && !wr_go |=> count == 16'hffff)
		else $error("underflow did not load ffff");
	chk_ovf_flag_set: assert property (ovf_set |=> control_ff[OVF_BIT])
		else $error("overflow flag not set");
	chk_ovf_sticky: assert property (control_ff[OVF_BIT] && !wr_control && !wr_bit |=> control_ff[OVF_BIT])
		else $error("overflow flag cleared without software");
	chk_clkout_no_flag: assert property (clock_out && !control_ff[OVF_BIT] && !wr_go |=> !control_ff[OVF_BIT])
		else $error("overflow flag set in clock-out mode");
	chk_pin_idle_low: assert property (!clock_out |=> count_clock_pin_o == 1'b0)
		else $error("clock-out pin active while disabled");
	chk_baud_no_flag: assert property (baud_mode && !control_ff[OVF_BIT] && !wr_go |=> !control_ff[OVF_BIT])
		else $error("overflow flag set in serial clock mode");
	chk_ext_toggle: assert property (ext_toggle && !wr_control && !wr_bit |=> control_ff[EXT_BIT] != $past(control_ff[EXT_BIT]))
		else $error("external flag did not toggle on wrap");
	chk_updn_no_irq: assert property (updn_mode && !control_ff[OVF_BIT] |-> !timer_irq_req_o)
		else $error("external flag raised interrupt in up/down mode");
	chk_capture_copy: assert property (capture |=> reload == $past(count))
		else $error("capture did not copy count");
	chk_ignore_trigger: assert property (dir_fall && !control_ff[EXEN_BIT] |-> !capture && !ext_reload)
		else $error("trigger edge acted while disabled");
	chk_clkout_toggle: assert property (clock_out && wrap |=> count_clock_pin_o != $past(count_clock_pin_o))
		else $error("clock-out pin did not toggle");
	chk_baud_route: assert property (control_ff[RX_BIT] && wrap |=> rx_baud_clock_o)
		else $error("overflow not routed to receive clock");
endmodule
`default_nettype wire

// ===== hdl/timer2_tick_if.sv
// Purpose: Carries the divided count ticks from prescaler to timer core
// Assumes: Single clock domain, ticks are one-cycle pulses
// Notes: None
`timescale 1ns/100ps
`default_nettype none
interface timer2_tick_if;
	logic div_timer_tick;
	logic div_clkout_tick;
	modport src (output div_timer_tick, output div_clkout_tick);
	modport dst (input div_timer_tick, input div_clkout_tick);
endinterface
`default_nettype wire

// ===== verification/timer2_pin_partner.sv
// Purpose: External count source, trigger source and clock-out load
// Assumes: Bench sets levels right after rising edges
// Notes: Period is measured in core clocks between rising pin edges
`timescale 1ns/100ps
`default_nettype none
module timer2_pin_partner (
	input wire logic core_clk_i,
	input wire logic drive_level_i,
	input wire logic trig_level_i,
	input wire logic out_level_i,
	input wire logic out_en_n_i,
	output logic count_pin_o,
	output logic trig_pin_o,
	output logic [15:0] period_o
);
	logic last_ff = 1'b0;
	logic [15:0] cnt_ff = 16'h0000;
	// Device wins the pin while it drives; source only counts as input
	assign count_pin_o = out_en_n_i ? drive_level_i : out_level_i;
	assign trig_pin_o = trig_level_i;
	always_ff @(posedge core_clk_i) begin
		last_ff <= count_pin_o;
		cnt_ff <= cnt_ff + 16'h0001;
		if (count_pin_o && !last_ff) begin
			period_o <= cnt_ff + 16'h0001;
			cnt_ff <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// ===== verification/timer2_reload_capture_clockout_test.sv
// Purpose: Register-level tests of the reload/capture/clock-out timer
// Assumes: Wishbone acks one cycle after the request edge
// Notes: Counts are read only while stopped or pin-clocked with the pin idle, reads of a running count tear
`timescale 1ns/100ps
`default_nettype none
module timer2_reload_capture_clockout_test import timer2_pkg::*;;
	logic core_clk_i, resetn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_sel_i;
	logic [ADR_W-1:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic pin_in, pin_out, pin_oe_n, trig_pin, t1_ovf, rx_clk, tx_clk, irq;
	logic drive_level, trig_level;
	logic [15:0] period, v;
	int miscompares = 0, n_compared = 0, cycles = 0, rx_n = 0, tx_n = 0, r0, t0;

	timer2_reload_capture_clockout DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.count_clock_pin_i(pin_in), .count_clock_pin_o(pin_out),
		.count_clock_pin_oe_n_o(pin_oe_n), .direction_trigger_pin_i(trig_pin),
		.timer1_overflow_i(t1_ovf), .rx_baud_clock_o(rx_clk), .tx_baud_clock_o(tx_clk),
		.timer_irq_req_o(irq));
	timer2_pin_partner partner (.core_clk_i(core_clk_i), .drive_level_i(drive_level),
		.trig_level_i(trig_level), .out_level_i(pin_out), .out_en_n_i(pin_oe_n),
		.count_pin_o(pin_in), .trig_pin_o(trig_pin), .period_o(period));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (rx_clk === 1'b1) rx_n++;
		if (tx_clk === 1'b1) tx_n++;
		// Whole run needs about 500 cycles
		if (cycles == 20000) begin
			miscompares++;
			report_and_stop();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {idx, 2'b00};
		wb_dat_i <= {24'h000000, d};
		do begin
			@(posedge core_clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic expect_reg(input string what, input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		check(what, {8'h00, q}, {8'h00, e});
	endtask
	task automatic set16(input logic [7:0] idx, input logic [15:0] d);
		wr(idx, d[7:0]);
		wr(idx + 8'h01, d[15:8]);
	endtask
	task automatic get16(input logic [7:0] idx, output logic [15:0] d);
		wb(1'b0, idx, 8'h00, d[7:0]);
		wb(1'b0, idx + 8'h01, 8'h00, d[15:8]);
	endtask
	// Each edge is held long enough for the two-flop synchroniser
	task automatic count_fall(input int k);
		repeat (k) begin
			drive_level <= 1'b0;
			repeat (6) @(posedge core_clk_i);
			drive_level <= 1'b1;
			repeat (6) @(posedge core_clk_i);
		end
	endtask
	task automatic trig_fall();
		trig_level <= 1'b0;
		repeat (6) @(posedge core_clk_i);
		trig_level <= 1'b1;
		repeat (6) @(posedge core_clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		resetn_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_sel_i = 4'hf;
		wb_adr_i = '0;
		wb_dat_i = 32'h00000000;
		drive_level = 1'b1;
		trig_level = 1'b1;
		t1_ovf = 1'b0;
		repeat (4) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		expect_reg("control reset", IDX_CONTROL, CONTROL_RESET);
		expect_reg("mode reset", IDX_MODE, {6'h00, MODE_RESET});
		expect_reg("unmapped", 8'h10, 8'h00);
		wr(IDX_CONTROL_BIT, 8'h0c);
		expect_reg("bit set", IDX_CONTROL, 8'h10);
		wr(IDX_CONTROL_BIT, 8'h04);
		expect_reg("bit clear", IDX_CONTROL, 8'h00);
		$display("test registers done");
		set16(IDX_COUNT_LOW, 16'h1234);
		wr(IDX_CONTROL, 8'h09);
		trig_fall();
		get16(IDX_RELOAD_LOW, v);
		check("capture", v, 16'h1234);
		expect_reg("capture flag", IDX_CONTROL, 8'h49);
		check("capture irq", irq, 16'h0001);
		wr(IDX_CONTROL, 8'h08);
		set16(IDX_RELOAD_LOW, 16'h5678);
		trig_fall();
		get16(IDX_COUNT_LOW, v);
		check("trigger reload", v, 16'h5678);
		set16(IDX_COUNT_LOW, 16'h0000);
		wr(IDX_CONTROL, 8'h00);
		trig_fall();
		wr(IDX_CONTROL, 8'h28);
		trig_fall();
		get16(IDX_COUNT_LOW, v);
		check("trigger ignored", v, 16'h0000);
		expect_reg("no trigger flag", IDX_CONTROL, 8'h28);
		$display("test trigger done");
		wr(IDX_CONTROL, 8'h02);
		set16(IDX_COUNT_LOW, 16'h00fe);
		wr(IDX_CONTROL, 8'h06);
		count_fall(3);
		wr(IDX_CONTROL, 8'h02);
		count_fall(2);
		get16(IDX_COUNT_LOW, v);
		check("pin count carry", v, 16'h0101);
		wr(IDX_CONTROL, 8'h03);
		set16(IDX_COUNT_LOW, 16'hffff);
		wr(IDX_CONTROL, 8'h07);
		count_fall(1);
		get16(IDX_COUNT_LOW, v);
		check("capture mode wrap", v, 16'h0000);
		expect_reg("capture mode flag", IDX_CONTROL, 8'h87);
		wr(IDX_MODE, 8'h01);
		trig_level <= 1'b0;
		set16(IDX_RELOAD_LOW, 16'h0010);
		set16(IDX_COUNT_LOW, 16'h0011);
		wr(IDX_CONTROL, 8'h06);
		count_fall(2);
		get16(IDX_COUNT_LOW, v);
		check("underflow", v, 16'hffff);
		expect_reg("underflow flags", IDX_CONTROL, 8'hc6);
		wr(IDX_CONTROL, 8'h46);
		check("no ext irq", irq, 16'h0000);
		trig_level <= 1'b1;
		repeat (6) @(posedge core_clk_i);
		count_fall(1);
		wr(IDX_CONTROL_BIT, 8'h02);
		get16(IDX_COUNT_LOW, v);
		check("up overflow", v, 16'h0010);
		expect_reg("up flags", IDX_CONTROL, 8'h82);
		wr(IDX_MODE, 8'h00);
		$display("test up down done");
		wr(IDX_CONTROL, 8'h00);
		set16(IDX_RELOAD_LOW, 16'hfffe);
		set16(IDX_COUNT_LOW, 16'hfffe);
		wr(IDX_CONTROL, 8'h04);
		repeat (60) @(posedge core_clk_i);
		expect_reg("timer overflow", IDX_CONTROL, 8'h84);
		check("overflow irq", irq, 16'h0001);
		wr(IDX_CONTROL_BIT, 8'h02);
		wr(IDX_CONTROL, 8'h00);
		check("irq cleared", irq, 16'h0000);
		$display("test overflow done");
		wr(IDX_MODE, 8'h02);
		set16(IDX_COUNT_LOW, 16'hfffe);
		check("pin driven", pin_oe_n, 16'h0000);
		r0 = rx_n;
		t0 = tx_n;
		wr(IDX_CONTROL, 8'h25);
		repeat (60) @(posedge core_clk_i);
		t1_ovf <= 1'b1;
		@(posedge core_clk_i);
		t1_ovf <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		check("clock-out period", period, 16'h0008);
		check("rx from timer", 16'(rx_n - r0 >= 10), 16'h0001);
		check("tx from timer1", 16'(tx_n - t0), 16'h0001);
		expect_reg("no flag", IDX_CONTROL, 8'h25);
		wr(IDX_CONTROL, 8'h00);
		wr(IDX_MODE, 8'h00);
		check("pin released", pin_oe_n, 16'h0001);
		$display("test clock out done");
		report_and_stop();
	end
endmodule
`default_nettype wire
